// [dv/mcrc_collision_retry_checker.sv]
`timescale 1ns/1ps
module mcrc_collision_retry_checker (
  // clock and reset
  input wire        clk_sys, arst_n,
  // apb slave
  input wire        psel, penable, pwrite, pready, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire [3:0]  pstrb,
  // transmitter side
  input wire        tx_start, tx_byte, tx_end, tx_collision, tx_in_window,
  input wire        tx_late_collision, tx_retry, tx_abort,
  input wire [5:0]  collision_window_length,
  input wire [3:0]  retry_limit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire       wr = psel && penable && pwrite;
  wire       wfull = wr && (pstrb == 4'hF || pstrb == 4'h3);
  wire [9:0] f = {collision_window_length, retry_limit};
  wire [9:0] pw = {pwdata[13:8], pwdata[3:0]};
  a_bus_ready: assert property (psel |-> pready && !pslverr)
    else $error("bus access not answered");
  a_unimpl_zero: assert property (psel && penable && !pwrite && paddr != 12'h010
    |-> (prdata & ~32'h0000_3F0F) == 0)
    else $error("unimplemented bits read nonzero");
  a_reset_fields: assert property ($rose(arst_n) |-> f == 10'h37F)
    else $error("fields not at reset value");
  a_byte_ignored: assert property (wr && !(pstrb inside {4'h3, 4'hC, 4'hF}) |=> $stable(f))
    else $error("byte write changed fields");
  a_word_write: assert property (wfull && paddr == 0 |=> f == $past(pw))
    else $error("word write not stored");
  a_set_alias: assert property (wfull && paddr == 12'h008 |=> f == ($past(f) | $past(pw)))
    else $error("set alias wrong");
  a_clear_alias: assert property (wfull && paddr == 12'h004 |=> f == ($past(f) & ~$past(pw)))
    else $error("clear alias wrong");
  a_inv_alias: assert property (wfull && paddr == 12'h00C |=> f == ($past(f) ^ $past(pw)))
    else $error("invert alias wrong");
  a_fields_hold: assert property (!wr |=> $stable(f))
    else $error("fields changed without write");
  a_abort_cause: assert property (tx_abort |-> $past(tx_collision, 2) && !$past(tx_abort))
    else $error("abort without collision");
endmodule // mcrc_collision_retry_checker
bind mcrc_collision_retry mcrc_collision_retry_checker u_chk (.*);

// [dv/mcrc_phy_model.sv]
`timescale 1ns/1ps
module mcrc_phy_model (
  // clock
  input  wire clk_sys,
  // collision outcome from the block
  input  wire tx_late_collision,
  input  wire tx_retry,
  // transmit events toward the block
  output reg  tx_start = 0,
  output reg  tx_byte = 0,
  output reg  tx_end = 0,
  output reg  tx_collision = 0
);
  reg seen_late = 0, seen_retry = 0;
  // one attempt of n bytes, ending in a collision or a clean finish; n must be at least 1
  task attempt(input int n, input bit col);
    tx_start <= 1;
    repeat (n) begin
      @(posedge clk_sys) tx_start <= 0;
      tx_byte <= 1;
    end
    @(posedge clk_sys) tx_byte <= 0;
    if (col) tx_collision <= 1;
    else tx_end <= 1;
    @(posedge clk_sys) tx_collision <= 0;
    tx_end <= 0;
  endtask
  // comb outcome is only meaningful in the collision cycle
  always @(posedge clk_sys) if (tx_collision) begin
    seen_late <= tx_late_collision;
    seen_retry <= tx_retry;
  end
endmodule // mcrc_phy_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  reg         clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, rd;
  reg  [3:0]  pstrb = 0;
  wire        pready, pslverr, tx_start, tx_byte, tx_end, tx_collision, tx_in_window;
  wire        tx_late_collision, tx_retry, tx_abort;
  wire [31:0] prdata;
  wire [5:0]  collision_window_length;
  wire [3:0]  retry_limit;
  int         miscompares = 0, num_checks = 0, i;
  logic [11:0] ad [8] = '{0, 0, 0, 12, 8, 4, 8, 0};
  logic [31:0] wd [8] = '{'1, 16'h2A05, 16'h2A05, 16'h0F0F, 16'h1000, 16'h0008, '1, '1};
  logic [3:0]  sb [8] = '{15, 1, 3, 15, 3, 15, 2, 12};
  logic [31:0] ex [8] = '{16'h3F0F, 16'h3F0F, 16'h2A05, 16'h250A, 16'h350A, 16'h3502, 16'h3502,
                          16'h3502};
  always #12.5 clk_sys = ~clk_sys;
  mcrc_collision_retry u_dut (.*);
  mcrc_phy_model u_phy (.*);
  task end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input bit w, input [11:0] a, input [31:0] d, input [3:0] s);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk_sys) penable <= 1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      end_of_test;
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task rst;
    arst_n <= 0;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1;
    @(posedge clk_sys);
    apb(0, 0, 0, 15);
  endtask
  // abort pulse stands in the second cycle after the collision is sampled
  task pkt(input int n, input bit col, input bit ab);
    u_phy.attempt(n, col);
    @(posedge clk_sys);
    #1 chk("abort", tx_abort, ab);
    @(posedge clk_sys);
  endtask
  initial begin
    rst; chk("reset", rd, 32'h0000_370F);
    for (i = 0; i < 8; i++) begin
      apb(1, ad[i], wd[i], sb[i]);
      apb(0, 0, 0, 15);
      chk("reg", rd, ex[i]);
    end
    apb(0, 12'h014, 0, 15); chk("unmapped", rd, 0);
    apb(1, 0, 32'h0000_3702, 15);
    repeat (2) pkt(3, 1, 0);
    pkt(3, 1, 1);
    repeat (2) pkt(3, 1, 0);
    pkt(3, 0, 0);
    repeat (2) pkt(3, 1, 0);
    pkt(3, 0, 0);
    apb(1, 0, 32'h0000_0402, 15);
    pkt(6, 1, 0); chk("late", u_phy.seen_late, 1);
    chk("noretry", u_phy.seen_retry, 0);
    pkt(2, 1, 0); chk("retry", u_phy.seen_retry, 1);
    chk("nolate", u_phy.seen_late, 0);
    apb(0, 12'h010, 0, 15); chk("status", rd, 32'h0000_0007);
    apb(1, 12'h010, 32'h0000_0003, 15);
    apb(0, 12'h010, 0, 15); chk("stclr", rd, 32'h0000_0004);
    rst; chk("rereset", rd, 32'h0000_370F);
    end_of_test;
  end
endmodule // testbench

// [rtl/mcrc_attempt_counter.v]
`timescale 1ns/1ps
// counts transmit attempts of one packet and flags abort once over the limit
module mcrc_attempt_counter #(
  parameter CNT_W = 5
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             arst_n,
  // events
  input  wire             pkt_start,
  input  wire             late_collision_free,
  input  wire             retry_req,
  input  wire [3:0]       retry_limit,
  // results
  output reg  [CNT_W-1:0] attempts,
  output reg              abort_pulse
);

  wire over_limit;
  assign over_limit = (attempts >= {1'b0, retry_limit});

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      attempts    <= {CNT_W{1'b0}};
      abort_pulse <= 1'b0;
    end else begin
      abort_pulse <= 1'b0;
      if (pkt_start) begin
        attempts <= {CNT_W{1'b0}};
      end else if (retry_req && late_collision_free) begin
        if (over_limit) begin
          abort_pulse <= 1'b1;
          attempts    <= {CNT_W{1'b0}};
        end else begin
          attempts <= attempts + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // mcrc_attempt_counter

// [rtl/mcrc_collision_retry.v]
// Functional notes
// - writable 6-bit collision window in bits 13:8
// - window counts from first byte, preamble included
// - window resets to 0x37 frame bytes
// - writable 4-bit retry limit in bits 3:0
// - abort packet once attempts exceed retry limit
// - retry limit resets to 0xF
// - bits 31:14 and 7:4 read zero
// - accept 16-bit and 32-bit accesses
// - set, clear, invert aliases act on masked bits
// - ignore byte-wide accesses, contents unchanged
`timescale 1ns/1ps
`include "mcrc_defines.vh"
module mcrc_collision_retry #(
  parameter CNT_W = 5
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        arst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // transmitter side
  input  wire        tx_start,
  input  wire        tx_byte,
  input  wire        tx_end,
  input  wire        tx_collision,
  output wire        tx_in_window,
  output wire        tx_late_collision,
  output wire        tx_retry,
  output reg         tx_abort,
  output wire [5:0]  collision_window_length,
  output wire [3:0]  retry_limit
);

  reg  [31:0]      collision_window_retry_limit;
  reg  [31:0]      next_reg;
  reg  [6:0]       byte_cnt;
  reg              in_frame;
  reg              late_seen;
  reg              abort_sticky;
  reg              late_sticky;
  reg              status_clear;
  wire [CNT_W-1:0] attempts;
  wire             abort_pulse;
  wire             wr_en;
  wire             strb_ok;
  wire [31:0]      lane_mask;
  wire [31:0]      wmask;
  wire             hit_reg;
  wire             at_limit;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;

  // only halfword or word strobes count; bytes are dropped silently
  assign strb_ok = (pstrb == `MCRC_STRB_LO16) || (pstrb == `MCRC_STRB_HI16) ||
                   (pstrb == `MCRC_STRB_ALL);
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{pstrb[lane]}};
    end
  endgenerate
  assign wmask     = lane_mask & `MCRC_IMPL_MASK;
  assign hit_reg   = (paddr == `MCRC_ADDR_BASE) || (paddr == `MCRC_ADDR_CLEAR_ALIAS) ||
                     (paddr == `MCRC_ADDR_SET) || (paddr == `MCRC_ADDR_INVERT_ALIAS);

  always @* begin
    next_reg = collision_window_retry_limit;
    if (wr_en && strb_ok) begin
      case (paddr)
        `MCRC_ADDR_BASE:
          next_reg = (collision_window_retry_limit & ~wmask) | (pwdata & wmask);
        `MCRC_ADDR_SET:
          next_reg = collision_window_retry_limit | (pwdata & wmask);
        `MCRC_ADDR_CLEAR_ALIAS:
          next_reg = collision_window_retry_limit & ~(pwdata & wmask);
        `MCRC_ADDR_INVERT_ALIAS:
          next_reg = collision_window_retry_limit ^ (pwdata & wmask);
        default:
          next_reg = collision_window_retry_limit;
      endcase
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      collision_window_retry_limit <= `MCRC_RESET_VALUE;
    end else begin
      collision_window_retry_limit <= next_reg & `MCRC_IMPL_MASK;
    end
  end

  assign collision_window_length =
    collision_window_retry_limit[`MCRC_CWIN_MSB:`MCRC_CWIN_LSB];
  assign retry_limit = collision_window_retry_limit[`MCRC_RETRY_MSB:`MCRC_RETRY_LSB];

  // status write of bit0 / bit1 clears stickies; set wins over clear
  always @* begin
    status_clear = wr_en && strb_ok && (paddr == `MCRC_ADDR_STATUS);
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_reg) begin
        prdata <= collision_window_retry_limit;
      end else if (paddr == `MCRC_ADDR_STATUS) begin
        prdata <= {{(32-CNT_W-2){1'b0}}, attempts, late_sticky, abort_sticky};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // byte counter starts at the first preamble byte
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      byte_cnt <= 7'h00;
      in_frame <= 1'b0;
    end else if (tx_start) begin
      byte_cnt <= 7'h00;
      in_frame <= 1'b1;
    end else if (tx_end || tx_collision) begin
      in_frame <= 1'b0;
    end else if (in_frame && tx_byte && (byte_cnt != `MCRC_BYTE_MAX)) begin
      byte_cnt <= byte_cnt + 7'h01;
    end
  end

  // collision is normal while fewer bytes than the window have gone out
  assign tx_in_window      = in_frame && (byte_cnt < {1'b0, collision_window_length});
  assign tx_late_collision = in_frame && tx_collision && !tx_in_window;
  // the collision that uses up the budget aborts instead of retrying
  assign at_limit          = (attempts >= {1'b0, retry_limit});
  assign tx_retry          = in_frame && tx_collision && tx_in_window && !at_limit;

  mcrc_attempt_counter #(
    .CNT_W (CNT_W)
  ) u_attempts (
    .clk_sys             (clk_sys),
    .arst_n              (arst_n),
    .pkt_start           (tx_start && !in_frame && !late_seen),
    .late_collision_free (tx_in_window),
    .retry_req           (in_frame && tx_collision),
    .retry_limit         (retry_limit),
    .attempts            (attempts),
    .abort_pulse         (abort_pulse)
  );

  // a fresh packet is one that follows an abort, a late collision or an end without collision
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      late_seen    <= 1'b0;
      tx_abort     <= 1'b0;
      abort_sticky <= 1'b0;
      late_sticky  <= 1'b0;
    end else begin
      // retry pending must survive the gap until the next attempt starts
      if (abort_pulse || tx_late_collision || (in_frame && tx_end)) begin
        late_seen <= 1'b0;
      end else if (tx_retry) begin
        late_seen <= 1'b1;
      end
      tx_abort  <= abort_pulse;
      if (abort_pulse) begin
        abort_sticky <= 1'b1;
      end else if (status_clear && pwdata[`MCRC_STAT_ABORT]) begin
        abort_sticky <= 1'b0;
      end
      if (tx_late_collision) begin
        late_sticky <= 1'b1;
      end else if (status_clear && pwdata[`MCRC_STAT_LATE]) begin
        late_sticky <= 1'b0;
      end
    end
  end

endmodule // mcrc_collision_retry

// [rtl/mcrc_defines.vh]
`ifndef MCRC_DEFINES_VH
`define MCRC_DEFINES_VH
// register byte addresses (chosen map: base, clear, set, invert aliases)
`define MCRC_ADDR_BASE          12'h000
`define MCRC_ADDR_CLEAR_ALIAS   12'h004
`define MCRC_ADDR_SET           12'h008
`define MCRC_ADDR_INVERT_ALIAS  12'h00C
`define MCRC_ADDR_STATUS  12'h010
`define MCRC_ADDR_CTRL    12'h014
// field layout of collision_window_retry_limit
`define MCRC_CWIN_LSB     8
`define MCRC_CWIN_MSB     13
`define MCRC_RETRY_LSB    0
`define MCRC_RETRY_MSB    3
// writable bits mask
`define MCRC_IMPL_MASK    32'h0000_3F0F
// reset value: window 0x37, retry limit 0xF
`define MCRC_RESET_VALUE  32'h0000_370F
`define MCRC_CWIN_RESET   6'h37
`define MCRC_RETRY_RESET  4'hF
// byte-enable patterns accepted (16-bit halves and full word)
`define MCRC_STRB_LO16    4'h3
`define MCRC_STRB_HI16    4'hC
`define MCRC_STRB_ALL     4'hF
// status register bit positions and byte counter ceiling
`define MCRC_STAT_ABORT   0
`define MCRC_STAT_LATE    1
`define MCRC_BYTE_MAX     7'h7F
`endif
